// *** design/sync_serial_port_control.sv ***
// Purpose: control, mode and status of a serial unit in synchronous port or UART role
// Assumes: 16-bit register port, read data one cycle after the read strobe
// Notes:   UART framing lives elsewhere; only its channel enables are kept here
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module sync_serial_port_control
   import sync_serial_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     rst_n,
   input  wire bus_req_t bus_req,
   output logic [15:0]   rdata,
   input  wire logic     sclk_in,
   output logic          sclk_out,
   output logic          sclk_oe,
   input  wire logic     sdi,
   output logic          sdo,
   output logic          sdo_oe,
   output logic          uart_ch0_enable,
   output logic          uart_ch1_enable
);
   typedef enum logic { ST_IDLE, ST_RUN } xfer_state_t;

   xfer_state_t state_reg;
   port_mode_t  mode_reg;
   logic [1:0]  unit_mode_reg;
   logic        sync_enable_reg;
   logic        sync_enable_d_reg;
   logic        buffer_full_reg;
   logic        tx_overrun_error_reg;
   logic        rx_overrun_error_reg;
   logic        tx_underrun_error_reg;
   logic        rx_unread_reg;
   logic [15:0] tx_buf_reg;
   logic [15:0] rx_data_reg;
   logic [15:0] tx_sh_reg;
   logic [15:0] rx_sh_reg;
   logic [4:0]  bit_cnt_reg;
   logic        clk_lvl_reg;
   logic        prev_lvl_reg;
   logic [1:0]  pins_s;

   logic sync_mode;
   logic is_slave;
   logic idle_lvl;
   logic tick;
   logic lead;
   logic trail;
   logic wr_low;
   logic wr_high;
   logic buf_start_wr;
   logic load;
   logic done;
   logic tx_on;
   logic rx_on;
   logic [4:0] nbits;
   logic [15:0] stat_word;
   logic [15:0] rx_word;

   // ****************************************
   // decode
   // ****************************************
   assign sync_mode = !unit_mode_reg[1];
   assign is_slave  = (mode_reg.clock_select == CKSEL_EXT);
   assign idle_lvl  = !mode_reg.clock_type;
   assign nbits     = mode_reg.word_length ? BITS_16 : BITS_8;
   assign tx_on     = mode_reg.transfer_mode[1];
   assign rx_on     = mode_reg.transfer_mode[0];
   assign wr_low    = bus_req.wr && (bus_req.addr == ADDR_DATA_BUFFER_LOW);
   assign wr_high   = bus_req.wr && (bus_req.addr == ADDR_DATA_BUFFER_HIGH);
   // a word write at the low address covers both bytes and so starts either length
   assign buf_start_wr = sync_mode && (wr_low || (wr_high && mode_reg.word_length));

   pin_sync #(.WIDTH(2)) u_pin_sync
   (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .pin_in       ({sclk_in, sdi}),
      .pin_sync_out (pins_s)
   );

   serial_clock_divider u_divider
   (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .clock_select (mode_reg.clock_select),
      .run          (state_reg == ST_RUN && !is_slave),
      .tick         (tick)
   );

   // ****************************************
   // transfer clock edges
   // ****************************************
   // slave edges come from the synchronised pin, polarity folded out
   always_comb
   begin
      lead  = 1'b0;
      trail = 1'b0;
      if (is_slave)
      begin
         lead  = (prev_lvl_reg == idle_lvl) && ((pins_s[1] ^ mode_reg.clock_polarity) != idle_lvl);
         trail = (prev_lvl_reg != idle_lvl) && ((pins_s[1] ^ mode_reg.clock_polarity) == idle_lvl);
      end
      else if (tick && state_reg == ST_RUN)
      begin
         lead  = (clk_lvl_reg == idle_lvl);
         trail = (clk_lvl_reg != idle_lvl);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prev_lvl_reg <= 1'b1;
      else
         prev_lvl_reg <= pins_s[1] ^ mode_reg.clock_polarity;
   end

   // master starts only with data; slave follows the master's first edge
   assign load = sync_enable_reg && (mode_reg.transfer_mode != XFER_STOP) && state_reg == ST_IDLE &&
                 (is_slave ? lead : buffer_full_reg);
   assign done = state_reg == ST_RUN && trail && (bit_cnt_reg == nbits - 5'h01);

   // ****************************************
   // transfer engine
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= ST_IDLE;
      else if (!sync_enable_reg)
         state_reg <= ST_IDLE;
      else
         unique case (state_reg)
            ST_IDLE: if (load) state_reg <= ST_RUN;
            ST_RUN:  if (done) state_reg <= ST_IDLE;
         endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         clk_lvl_reg <= 1'b1;
      else if (state_reg != ST_RUN || is_slave)
         clk_lvl_reg <= idle_lvl;
      else if (tick)
         clk_lvl_reg <= !clk_lvl_reg;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         bit_cnt_reg <= '0;
      else if (load)
         bit_cnt_reg <= '0;
      else if (state_reg == ST_RUN && trail)
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tx_sh_reg <= '0;
      else if (load)
         tx_sh_reg <= tx_buf_reg;
      else if (state_reg == ST_RUN && trail)
         tx_sh_reg <= mode_reg.bit_order ? {tx_sh_reg[14:0], 1'b0} : {1'b0, tx_sh_reg[15:1]};
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rx_sh_reg <= '0;
      else if (state_reg == ST_RUN && trail)
         rx_sh_reg <= mode_reg.bit_order ? {rx_sh_reg[14:0], pins_s[0]} : {pins_s[0], rx_sh_reg[15:1]};
   end

   // lsb-first words arrive at the top of the shifter
   assign rx_word = mode_reg.bit_order ? (mode_reg.word_length ? rx_sh_reg : {8'h00, rx_sh_reg[7:0]})
                  : (mode_reg.word_length ? {pins_s[0], rx_sh_reg[15:1]} : {8'h00, pins_s[0], rx_sh_reg[15:9]});

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rx_data_reg <= '0;
      else if (done && rx_on)
         rx_data_reg <= mode_reg.bit_order ? {rx_word[14:0], pins_s[0]} : rx_word;
   end

   // ****************************************
   // pins
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_out <= 1'b1;
         sclk_oe  <= 1'b0;
         sdo      <= 1'b1;
         sdo_oe   <= 1'b0;
      end
      else
      begin
         sclk_out <= clk_lvl_reg ^ mode_reg.clock_polarity;
         sclk_oe  <= sync_enable_reg && !is_slave;
         sdo      <= mode_reg.bit_order ? (mode_reg.word_length ? tx_sh_reg[15] : tx_sh_reg[7]) : tx_sh_reg[0];
         sdo_oe   <= sync_enable_reg && tx_on;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         unit_mode_reg <= RST_UNIT_MODE;
      else if (bus_req.wr && bus_req.addr == ADDR_UNIT_MODE)
         unit_mode_reg <= bus_req.wdata[1:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_enable_reg <= RST_UNIT_CH_ENABLE[BIT_SYNC_ENABLE];
         uart_ch0_enable <= RST_UNIT_CH_ENABLE[BIT_UART_CH0];
         uart_ch1_enable <= RST_UNIT_CH_ENABLE[BIT_UART_CH1];
      end
      else if (bus_req.wr && bus_req.addr == ADDR_UNIT_CH_ENABLE)
      begin
         if (sync_mode)
            sync_enable_reg <= bus_req.wdata[BIT_SYNC_ENABLE];
         if (!sync_mode)
            uart_ch0_enable <= bus_req.wdata[BIT_UART_CH0];
         if (unit_mode_reg == UNIT_UART_HALF)
            uart_ch1_enable <= bus_req.wdata[BIT_UART_CH1];
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sync_enable_d_reg <= 1'b0;
      else
         sync_enable_d_reg <= sync_enable_reg;
   end

   // reserved bits are kept at zero
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         mode_reg <= RST_SYNC_PORT_MODE;
      else if (bus_req.wr && bus_req.addr == ADDR_SYNC_PORT_MODE)
      begin
         mode_reg        <= bus_req.wdata;
         mode_reg.rsv15  <= 1'b0;
         mode_reg.rsv7_4 <= 4'h0;
      end
   end

   // ****************************************
   // data buffer
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tx_buf_reg <= '0;
      else if (wr_low)
         tx_buf_reg <= bus_req.wdata;
      else if (wr_high)
         tx_buf_reg[15:8] <= bus_req.wdata[7:0];
   end

   // a buffer write in the load cycle wins over the clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         buffer_full_reg <= RST_SYNC_PORT_STAT[BIT_FULL];
      else if (buf_start_wr)
         buffer_full_reg <= 1'b1;
      else if (load)
         buffer_full_reg <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rx_unread_reg <= 1'b0;
      else if (done && rx_on)
         rx_unread_reg <= 1'b1;
      else if (bus_req.rd && bus_req.addr == ADDR_DATA_BUFFER_LOW)
         rx_unread_reg <= 1'b0;
   end

   // ****************************************
   // error flags: set wins over write-one clear
   // ****************************************
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_overrun_error_reg  <= RST_SYNC_PORT_STAT[BIT_TOER];
         rx_overrun_error_reg  <= RST_SYNC_PORT_STAT[BIT_ROER];
         tx_underrun_error_reg <= RST_SYNC_PORT_STAT[BIT_TUER];
      end
      else
      begin
         if (buf_start_wr && buffer_full_reg)
            tx_overrun_error_reg <= 1'b1;
         else if (bus_req.wr && bus_req.addr == ADDR_SYNC_PORT_STAT && bus_req.wdata[BIT_TOER])
            tx_overrun_error_reg <= 1'b0;
         if (done && rx_on && rx_unread_reg)
            rx_overrun_error_reg <= 1'b1;
         else if (bus_req.wr && bus_req.addr == ADDR_SYNC_PORT_STAT && bus_req.wdata[BIT_ROER])
            rx_overrun_error_reg <= 1'b0;
         if (tx_on && !buffer_full_reg &&
             (load || (is_slave && mode_reg.clock_type &&
                       ((sync_enable_reg && !sync_enable_d_reg) || done))))
            tx_underrun_error_reg <= 1'b1;
         else if (bus_req.wr && bus_req.addr == ADDR_SYNC_PORT_STAT && bus_req.wdata[BIT_TUER])
            tx_underrun_error_reg <= 1'b0;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   assign stat_word = {8'h00, 2'b00,
                       state_reg == ST_RUN && rx_on,
                       state_reg == ST_RUN && tx_on,
                       buffer_full_reg, tx_overrun_error_reg,
                       rx_overrun_error_reg, tx_underrun_error_reg};

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= '0;
      else if (bus_req.rd)
         unique case (bus_req.addr)
            ADDR_DATA_BUFFER_LOW:  rdata <= rx_data_reg;
            ADDR_DATA_BUFFER_HIGH: rdata <= {8'h00, rx_data_reg[15:8]};
            ADDR_UNIT_MODE:        rdata <= {14'h0000, unit_mode_reg};
            ADDR_UNIT_CH_ENABLE:   rdata <= {6'h00, uart_ch1_enable, 7'h00, uart_ch0_enable, sync_enable_reg};
            ADDR_SYNC_PORT_MODE:   rdata <= mode_reg;
            ADDR_SYNC_PORT_STAT:   rdata <= stat_word;
            default:               rdata <= 16'h0000;
         endcase
      else
         rdata <= 16'h0000;
   end
endmodule // sync_serial_port_control
`default_nettype wire

// *** design/sync_serial_pkg.sv ***
// Purpose: shared constants and types of the synchronous serial port control block
// Assumes: 100 MHz mclk; registers reached over a plain 16-bit strobe port
// Notes:   register offsets are byte addresses of the register port
`default_nettype none
package sync_serial_pkg;
   // ****************************************
   // clocking
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int LS_PERIOD_NS  = 30518;                       // low speed clock period, ns
   localparam int LS_DIV        = LS_PERIOD_NS / CLK_PERIOD_NS; // rounds down

   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] ADDR_DATA_BUFFER_LOW = 16'hF600;
   localparam logic [15:0] ADDR_DATA_BUFFER_HIGH = 16'hF601;
   localparam logic [15:0] ADDR_UNIT_MODE      = 16'hF602;
   localparam logic [15:0] ADDR_UNIT_CH_ENABLE = 16'hF606;
   localparam logic [15:0] ADDR_SYNC_PORT_MODE = 16'hF608;
   localparam logic [15:0] ADDR_SYNC_PORT_STAT = 16'hF60A;

   localparam logic [15:0] RST_UNIT_CH_ENABLE = 16'h0000;
   localparam logic [15:0] RST_SYNC_PORT_MODE = 16'h0000;
   localparam logic [7:0]  RST_SYNC_PORT_STAT = 8'h00;
   localparam logic [1:0]  RST_UNIT_MODE      = 2'h0;

   // unit_channel_enable fields
   localparam int BIT_SYNC_ENABLE = 0;
   localparam int BIT_UART_CH0    = 1;
   localparam int BIT_UART_CH1    = 9;

   // sync_port_status fields
   localparam int BIT_TUER = 0;
   localparam int BIT_ROER = 1;
   localparam int BIT_TOER = 2;
   localparam int BIT_FULL = 3;
   localparam int BIT_TXF  = 4;
   localparam int BIT_RXF  = 5;

   // unit modes
   localparam logic [1:0] UNIT_UART_FULL = 2'h2;
   localparam logic [1:0] UNIT_UART_HALF = 2'h3;

   // clock select codes
   localparam logic [4:0] CKSEL_LS      = 5'h00;
   localparam logic [4:0] CKSEL_LS_DIV2 = 5'h01;
   localparam logic [4:0] CKSEL_EXT     = 5'h18;

   // transfer modes
   localparam logic [1:0] XFER_STOP = 2'h0;
   localparam logic [1:0] XFER_RX   = 2'h1;
   localparam logic [1:0] XFER_TX   = 2'h2;
   localparam logic [1:0] XFER_TRX  = 2'h3;

   localparam logic [4:0] BITS_8  = 5'h08;
   localparam logic [4:0] BITS_16 = 5'h10;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   // layout equals the sync_port_mode register
   typedef struct packed {
      logic       rsv15;
      logic       clock_polarity;
      logic       clock_type;
      logic [4:0] clock_select;
      logic [3:0] rsv7_4;
      logic       word_length;
      logic [1:0] transfer_mode;
      logic       bit_order;
   } port_mode_t;
endpackage
`default_nettype wire

// *** design/pin_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   only the second stage may be read by logic
`default_nettype none
module pin_sync #(parameter int WIDTH = 2)
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_reg   <= '0;
         pin_sync_out <= '0;
      end
      else
      begin
         stage1_reg   <= pin_in;
         pin_sync_out <= stage1_reg;
      end
   end
endmodule // pin_sync
`default_nettype wire

// *** design/serial_clock_divider.sv ***
// Purpose: one-cycle tick per transfer clock edge, at twice the selected transfer clock rate
// Assumes: mclk serves as the high speed clock
// Notes:   low speed clock is an enable derived from mclk
`default_nettype none
module serial_clock_divider
   import sync_serial_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [4:0] clock_select,
   input  wire logic       run,
   output logic            tick
);
   logic [11:0] ls_cnt_reg;
   logic        ls_tick;
   logic [6:0]  div_cnt_reg;
   logic        hs_sel;
   logic        src;
   logic [6:0]  last;

   // low speed enable runs free
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ls_cnt_reg <= '0;
      else if (ls_cnt_reg == 12'(LS_DIV - 1))
         ls_cnt_reg <= '0;
      else
         ls_cnt_reg <= ls_cnt_reg + 12'h001;
   end
   assign ls_tick = (ls_cnt_reg == 12'(LS_DIV - 1));

   // undefined codes fall back to the low speed clock
   assign hs_sel = (clock_select[4:3] == 2'b10);
   assign src    = hs_sel ? 1'b1 : ls_tick;
   always_comb
   begin
      if (hs_sel)
         last = 7'((8'h01 << clock_select[2:0]) - 8'h01);
      else if (clock_select == CKSEL_LS_DIV2)
         last = 7'h01;
      else
         last = 7'h00;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         div_cnt_reg <= '0;
      else if (!run)
         div_cnt_reg <= '0;
      else if (src)
         div_cnt_reg <= (div_cnt_reg >= last) ? 7'h00 : div_cnt_reg + 7'h01;
   end
   assign tick = run && src && (div_cnt_reg >= last);
endmodule // serial_clock_divider
`default_nettype wire

// *** verification/sync_serial_port_control_properties.sv ***
// Purpose: port-level checks of the serial port control block
// Assumes: one clock domain, rst_n active low
// Notes:   bound to the design from tb
`default_nettype none
module sync_serial_properties
   import sync_serial_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire bus_req_t    bus_req,
   input wire logic [15:0] rdata,
   input wire logic        sclk_in,
   input wire logic        sclk_out,
   input wire logic        sclk_oe,
   input wire logic        sdi,
   input wire logic        sdo,
   input wire logic        sdo_oe,
   input wire logic        uart_ch0_enable,
   input wire logic        uart_ch1_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence mode_wr_rd;
      bus_req.wr && bus_req.addr == ADDR_UNIT_MODE ##1 !bus_req.wr ##1 bus_req.rd && bus_req.addr == ADDR_UNIT_MODE;
   endsequence

   AST_RDATA_IDLE: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
      else $error("read data outside its slot");
   AST_STAT_RSVD: assert property ($past(bus_req.rd && bus_req.addr == ADDR_SYNC_PORT_STAT) |->
      rdata[15:6] == 10'h000) else $error("status upper bits not zero");
   AST_CH0_CAUSE: assert property ($changed(uart_ch0_enable) |->
      $past(bus_req.wr && bus_req.addr == ADDR_UNIT_CH_ENABLE)) else $error("channel 0 moved without write");
   AST_CH1_SET: assert property ($rose(uart_ch1_enable) |->
      $past(bus_req.wr && bus_req.wdata[BIT_UART_CH1])) else $error("channel 1 rose without a one written");
   AST_UNIT_MODE_READ: assert property (mode_wr_rd |=> rdata == {14'h0000, $past(bus_req.wdata[1:0], 3)})
      else $error("unit mode readback wrong");
   AST_SCLK_OE_CAUSE: assert property ($rose(sclk_oe) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
      else $error("clock drive began without a write");
   AST_SDO_OE_CAUSE: assert property ($changed(sdo_oe) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
      else $error("data drive moved without a write");
   // a mode write reaches the pin in at most three register steps (clock_type via clk_lvl_reg), so three cycles are excluded
   AST_SCLK_QUIET: assert property (!sclk_oe && !$past(sclk_oe) && !$past(sclk_oe, 2) &&
      !$past(bus_req.wr) && !$past(bus_req.wr, 2) && !$past(bus_req.wr, 3) |-> $stable(sclk_out))
      else $error("clock moved while undriven");

   cover property ($rose(sclk_oe));
   cover property ($rose(sdo_oe));
   cover property ($rose(uart_ch1_enable));
endmodule // sync_serial_properties
`default_nettype wire

// *** verification/serial_peer_model.sv ***
// Purpose: far-side serial peer: captures sdo, drives sdi, makes a slave clock
// Assumes: idle gives the rest level of the clock for the current setting
// Notes:   captures on the leading edge, shifts on the return-to-idle edge
`default_nettype none
module serial_peer_model
(
   input  wire logic        mclk,
   input  wire logic        arm,
   input  wire logic        gen,
   input  wire logic        idle,
   input  wire logic [4:0]  nbits,
   input  wire logic [15:0] pattern,
   input  wire logic        sclk_line,
   input  wire logic        sdo,
   output logic             sdi,
   output logic             gclk,
   output logic [15:0]      capt,
   output logic [5:0]       count
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // peer behaviour
   // ****************************************
   logic        prev;
   logic [15:0] tx;
   int          div;
   int          edges;

   // spent bits are refilled inverted, so stale data never looks valid
   assign sdi = tx[15];

   always_ff @(posedge mclk)
   begin
      prev <= sclk_line;
      if (arm)
      begin
         tx <= pattern << (16 - nbits);
         capt <= 16'h0000;
         count <= 6'h00;
         gclk <= idle;
         edges <= 0;
         div <= 0;
      end
      else
      begin
         if (prev == idle && sclk_line != idle)
         begin
            capt <= {capt[14:0], sdo};
            count <= count + 6'h01;
         end
         if (prev != idle && sclk_line == idle)
            tx <= {tx[14:0], ~tx[15]};
         // half period of 60 cycles keeps the clock under 1 MHz and under an eighth of mclk
         if (gen && edges < 2 * nbits)
         begin
            div <= (div == 59) ? 0 : div + 1;
            if (div == 59)
            begin
               gclk <= ~gclk;
               edges <= edges + 1;
            end
         end
         else
            gclk <= idle;
      end
   end
endmodule // serial_peer_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: self-checking bench of the serial port control block
// Assumes: master runs at high speed clock / 64, slave clock from the peer
// Notes:   random data from an lfsr seeded with 47
`default_nettype none
module tb
   import sync_serial_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // bench
   // ****************************************
   localparam logic [15:0] ST = ADDR_SYNC_PORT_STAT;
   localparam logic [15:0] CE = ADDR_UNIT_CH_ENABLE;
   logic        mclk, rst_n, sclk_out, sclk_oe, sdo, sdo_oe, ch0, ch1, sdi, gclk, line;
   logic        arm, gen, idle, pol, typ, ord, len;
   logic [1:0]  tm;
   logic [4:0]  nb;
   logic [5:0]  cnt;
   logic [15:0] rdata, capt, pat, s, lf, d1, d2, msk;
   logic [15:0] rst_addr [5];
   bus_req_t    req;
   int          n_mismatch, samples_checked, nbits;

   assign line = sclk_oe ? sclk_out : gclk;

   sync_serial_port_control uut (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .rdata(rdata), .sclk_in(line),
      .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .uart_ch0_enable(ch0), .uart_ch1_enable(ch1));
   serial_peer_model peer (.mclk(mclk), .arm(arm), .gen(gen), .idle(idle), .nbits(nb), .pattern(pat),
      .sclk_line(line), .sdo(sdo), .sdi(sdi), .gclk(gclk), .capt(capt), .count(cnt));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic wr16(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge mclk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      s = rdata;
      if (m !== 16'h0000)
         check(s & m, e);
   endtask

   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // polls both busy flags; a stuck flag ends the run
   task automatic wait_idle();
      for (int k = 0; k < 3000; k++)
      begin
         rd_chk(ST, 16'h0000, 16'h0000);
         if ((s & 16'h0030) === 16'h0000)
            return;
      end
      n_mismatch++;
      close_out();
   endtask

   function automatic logic [15:0] order_bits(input logic [15:0] d, input int n, input logic msb);
      order_bits = 16'h0000;
      for (int i = 0; i < n; i++)
         order_bits[i] = msb ? d[i] : d[n - 1 - i];
   endfunction

   function automatic logic [15:0] next_rand();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial
   begin
      rst_n = 1'b0;
      req = '0;
      arm = 1'b1;
      gen = 1'b0;
      idle = 1'b1;
      nb = 5'h08;
      pat = 16'h0000;
      lf = 16'h002F;
      n_mismatch = 0;
      samples_checked = 0;
      rst_addr = '{ADDR_UNIT_MODE, CE, ADDR_SYNC_PORT_MODE, ST, 16'hF604};
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      arm <= 1'b0;
      for (int i = 0; i < 5; i++)
         rd_chk(rst_addr[i], 16'h0000, 16'hFFFF);
      for (int m = 0; m < 4; m++)
      begin
         wr16(ADDR_UNIT_MODE, 16'(m));
         rd_chk(ADDR_UNIT_MODE, 16'(m), 16'hFFFF);
         wr16(CE, 16'h0203);
         rd_chk(CE, (m < 2) ? 16'h0001 : (m == 2) ? 16'h0002 : 16'h0202, 16'hFFFF);
         check({14'h0000, ch1, ch0}, (m < 2) ? 16'h0000 : (m == 2) ? 16'h0001 : 16'h0003);
         wr16(CE, 16'h0000);
      end
      wr16(ADDR_UNIT_MODE, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         tm = 2'(i);
         {typ, pol} = tm;
         ord = tm[0] ^ tm[1];
         len = tm[0];
         nbits = len ? 16 : 8;
         msk = len ? 16'hFFFF : 16'h00FF;
         d1 = next_rand();
         d2 = next_rand();
         pat <= next_rand();
         idle <= ~typ ^ pol;
         nb <= 5'(nbits);
         wr16(CE, 16'h0000);
         wr16(ADDR_SYNC_PORT_MODE, {1'b0, pol, typ, 5'h15, 4'h0, len, tm, ord});
         arm_peer();
         wr16(ADDR_DATA_BUFFER_LOW, d1);
         wr16(ADDR_DATA_BUFFER_LOW, d2);
         rd_chk(ST, 16'h000C, 16'hFFFF);
         wr16(ST, 16'h0003);
         rd_chk(ST, 16'h000C, 16'hFFFF);
         wr16(ST, 16'h0004);
         rd_chk(ST, 16'h0008, 16'hFFFF);
         wr16(CE, 16'h0001);
         repeat (2) @(posedge mclk);
         rd_chk(ST, {10'h000, tm[0], tm[1], tm == 2'h0, 3'h0}, 16'hFFFF);
         check({14'h0000, sclk_oe, sdo_oe}, {14'h0000, 1'b1, tm[1]});
         wait_idle();
         check({10'h000, cnt}, (tm == 2'h0) ? 16'h0000 : 16'(nbits));
         if (tm[1])
            check(capt & msk, order_bits(d2, nbits, ord));
         if (tm[0])
            rd_chk(ADDR_DATA_BUFFER_LOW, order_bits(pat, nbits, ord), msk);
         check({15'h0000, sclk_out}, {15'h0000, ~typ ^ pol});
      end
      wr16(CE, 16'h0000);
      wr16(ADDR_SYNC_PORT_MODE, 16'h1804); // external clock selected: slave, transmit only, 8-bit words, lsb first
      idle <= 1'b1;
      nb <= 5'h08;
      arm_peer();
      wr16(CE, 16'h0001);
      rd_chk(ST, 16'h0000, 16'hFFFF);
      check({15'h0000, sclk_oe}, 16'h0000);
      gen <= 1'b1;
      for (int k = 0; k < 3000 && cnt !== 6'h08; k++)
         @(posedge mclk);
      if (cnt !== 6'h08)
      begin
         n_mismatch++;
         close_out();
      end
      wait_idle();
      gen <= 1'b0;
      rd_chk(ST, 16'h0001, 16'h003F);
      wr16(ST, 16'h0001);
      rd_chk(ST, 16'h0000, 16'h003F);
      close_out();
   end

   task automatic arm_peer();
      arm <= 1'b1;
      repeat (2) @(posedge mclk);
      arm <= 1'b0;
   endtask
endmodule // tb

bind sync_serial_port_control sync_serial_properties props (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
   .rdata(rdata), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdi(sdi), .sdo(sdo),
   .sdo_oe(sdo_oe), .uart_ch0_enable(uart_ch0_enable), .uart_ch1_enable(uart_ch1_enable));
`default_nettype wire
